//--- core/nvb_pkg.sv
// nvb_pkg: constants and carrier types for the non-volatile byte access block.
// assumes a cpu-side special function register port and one system clock.
package nvb_pkg;

	// register placement
	localparam logic [7:0] NVB_CTRL_ADDR   = 8'h40;
	localparam logic [2:0] NVB_CTRL_BANK   = 3'h1;
	localparam logic [2:0] NVB_DIRECT_BANK = 3'h0;
	localparam logic [7:0] NVB_INDEX_ADDR  = 8'h2c;
	localparam logic [7:0] NVB_VALUE_ADDR  = 8'h2d;

	// nv_control field positions
	localparam int NVB_CTL_PROG_PERMIT  = 3;
	localparam int NVB_CTL_PROG_GO      = 2;
	localparam int NVB_CTL_FETCH_PERMIT = 1;
	localparam int NVB_CTL_FETCH_GO     = 0;

	// reset values
	localparam logic [6:0] NVB_INDEX_RST = 7'h00;
	localparam logic [7:0] NVB_VALUE_RST = 8'h00;
	localparam logic [3:0] NVB_CTRL_RST  = 4'h0;

	// array shape
	localparam int NVB_DEPTH  = 128;
	localparam int NVB_AW     = 7;
	localparam int NVB_DW     = 8;

	// timing counts
	localparam logic [7:0] NVB_WR_SUB_TICKS = 8'h40;
	localparam logic [1:0] NVB_RD_CYCLES    = 2'h2;

	typedef enum logic [1:0] {
		NVB_IDLE  = 2'b00,
		NVB_FETCH = 2'b01,
		NVB_PROG  = 2'b10
	} nvb_state_t;

	// one cpu register access
	typedef struct packed {
		logic [7:0] addr;
		logic [2:0] bank;
		logic       indirect;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} nvb_sfr_req_t;

endpackage : nvb_pkg

//--- core/nvb_array.sv
// nvb_array: 128 x 8 storage with one write and one registered read port.
// assumes the controller issues at most one access per cycle.
`timescale 1ns/100ps
`default_nettype none
module nvb_array
	import nvb_pkg::*;
(
	// clock
	input  wire logic              clk_sys_i,
	// write port
	input  wire logic              we_i,
	input  wire logic [NVB_AW-1:0] waddr_i,
	input  wire logic [NVB_DW-1:0] wdata_i,
	// read port
	input  wire logic [NVB_AW-1:0] raddr_i,
	output logic      [NVB_DW-1:0] rdata_o
);

	// no reset: contents survive like the real cells
	logic [NVB_DW-1:0] cells [NVB_DEPTH];

	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			cells[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		rdata_o <= cells[raddr_i];
	end

endmodule : nvb_array
`default_nettype wire

//--- core/nvb_ctrl.sv
// nvb_ctrl: byte access controller for the on-chip non-volatile data memory.
// assumes cpu register strobes on clk_sys_i and a free-running slow clock pin.
//
// Function
// - 128 bytes reached one byte per operation via three registers.
// - index and value in bank 0 direct; control at 40h bank 1 indirect.
// - index register holds 7 bits, bit 7 reads zero, resets zero.
// - value register is full 8-bit read/write, resets zero.
// - control bits 7..4 read zero; bits 3..0 reset zero.
// - program permit gates every write cycle.
// - program go starts write; hardware clears it when done.
// - program go ignored unless program permit already set.
// - fetch permit gates every read cycle.
// - fetch go starts read; hardware clears it when done.
// - fetch go ignored unless fetch permit already set.
// - value register holds fetched byte until next read cycle or cpu write to value.
// - write duration timed on slow clock, synchronised before go clears.
// - every write end sets a done request flag.
`timescale 1ns/100ps
`default_nettype none
module nvb_ctrl
	import nvb_pkg::*;
(
	// clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	// cpu register port
	input  wire nvb_sfr_req_t sfr_req_i,
	output logic       [7:0]  sfr_rdata_o,
	// slow substitute clock pin
	input  wire logic         fsub_i,
	// done request to interrupt logic
	input  wire logic         done_clr_i,
	output logic              nv_done_flag_o,
	// status
	output logic              busy_o
);

	nvb_state_t        state_q;
	logic [NVB_AW-1:0] index_q;
	logic [NVB_DW-1:0] value_q;
	logic              prog_permit_q;
	logic              prog_go_q;
	logic              fetch_permit_q;
	logic              fetch_go_q;
	logic [NVB_AW-1:0] cap_addr_q;
	logic [NVB_DW-1:0] cap_data_q;
	logic [7:0]        sub_cnt_q;
	logic [1:0]        rd_cnt_q;
	logic              fsub_meta_q;
	logic              fsub_sync_q;
	logic              fsub_prev_q;
	logic              mem_we_q;
	logic [NVB_DW-1:0] mem_rdata;
	logic              fsub_rise;
	logic              hit_index;
	logic              hit_value;
	logic              hit_ctrl;
	logic              ctl_wr;
	logic              start_prog;
	logic              start_fetch;
	logic              prog_end;
	logic              fetch_end;
	logic [7:0]        rd_mux;

	assign hit_index = (sfr_req_i.addr == NVB_INDEX_ADDR) &&
	                   (!sfr_req_i.indirect || sfr_req_i.bank == NVB_DIRECT_BANK);
	assign hit_value = (sfr_req_i.addr == NVB_VALUE_ADDR) &&
	                   (!sfr_req_i.indirect || sfr_req_i.bank == NVB_DIRECT_BANK);
	assign hit_ctrl  = (sfr_req_i.addr == NVB_CTRL_ADDR) && sfr_req_i.indirect &&
	                   (sfr_req_i.bank == NVB_CTRL_BANK);
	assign ctl_wr    = sfr_req_i.wr && hit_ctrl;

	assign start_prog  = ctl_wr && sfr_req_i.wdata[NVB_CTL_PROG_GO] && prog_permit_q &&
	                     (state_q == NVB_IDLE);
	// fetch permit must predate go; write takes precedence
	assign start_fetch = ctl_wr && sfr_req_i.wdata[NVB_CTL_FETCH_GO] && fetch_permit_q &&
	                     (state_q == NVB_IDLE) && !start_prog;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fsub_meta_q <= 1'b0;
			fsub_sync_q <= 1'b0;
			fsub_prev_q <= 1'b0;
		end else begin
			fsub_meta_q <= fsub_i;
			fsub_sync_q <= fsub_meta_q;
			fsub_prev_q <= fsub_sync_q;
		end
	end
	assign fsub_rise = fsub_sync_q && !fsub_prev_q;

	// write ends on last slow tick
	assign prog_end  = (state_q == NVB_PROG) && fsub_rise &&
	                   (sub_cnt_q == NVB_WR_SUB_TICKS - 8'h01);
	assign fetch_end = (state_q == NVB_FETCH) && (rd_cnt_q == NVB_RD_CYCLES - 2'h1);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= NVB_IDLE;
		end else begin
			unique case (state_q)
				NVB_IDLE: begin
					if (start_prog) begin
						state_q <= NVB_PROG;
					end else if (start_fetch) begin
						state_q <= NVB_FETCH;
					end
				end
				NVB_FETCH: begin
					if (fetch_end) begin
						state_q <= NVB_IDLE;
					end
				end
				NVB_PROG: begin
					if (prog_end) begin
						state_q <= NVB_IDLE;
					end
				end
				default: begin
					state_q <= NVB_IDLE;
				end
			endcase
		end
	end

	// cycle counters
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sub_cnt_q <= 8'h00;
			rd_cnt_q  <= 2'h0;
		end else begin
			if (state_q != NVB_PROG) begin
				sub_cnt_q <= 8'h00;
			end else if (fsub_rise) begin
				sub_cnt_q <= sub_cnt_q + 8'h01;
			end
			if (state_q != NVB_FETCH) begin
				rd_cnt_q <= 2'h0;
			end else begin
				rd_cnt_q <= rd_cnt_q + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			index_q <= NVB_INDEX_RST;
		end else if (sfr_req_i.wr && hit_index) begin
			index_q <= sfr_req_i.wdata[NVB_AW-1:0];
		end
	end

	// value register; fetched byte held until next load
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			value_q <= NVB_VALUE_RST;
		end else if (fetch_end) begin
			value_q <= mem_rdata;
		end else if (sfr_req_i.wr && hit_value) begin
			value_q <= sfr_req_i.wdata;
		end
	end

	// control bits; permits are plain storage
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_permit_q  <= NVB_CTRL_RST[NVB_CTL_PROG_PERMIT];
			fetch_permit_q <= NVB_CTRL_RST[NVB_CTL_FETCH_PERMIT];
		end else if (ctl_wr) begin
			prog_permit_q  <= sfr_req_i.wdata[NVB_CTL_PROG_PERMIT];
			fetch_permit_q <= sfr_req_i.wdata[NVB_CTL_FETCH_PERMIT];
		end
	end

	// go bits set by start, cleared only by hardware
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_go_q  <= NVB_CTRL_RST[NVB_CTL_PROG_GO];
			fetch_go_q <= NVB_CTRL_RST[NVB_CTL_FETCH_GO];
		end else begin
			if (start_prog) begin
				prog_go_q <= 1'b1;
			end else if (prog_end) begin
				prog_go_q <= 1'b0;
			end
			if (start_fetch) begin
				fetch_go_q <= 1'b1;
			end else if (fetch_end) begin
				fetch_go_q <= 1'b0;
			end
		end
	end

	// capture index and value at write start
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap_addr_q <= NVB_INDEX_RST;
			cap_data_q <= NVB_VALUE_RST;
			mem_we_q   <= 1'b0;
		end else begin
			if (start_prog) begin
				cap_addr_q <= index_q;
				cap_data_q <= value_q;
			end
			// cell write lands one cycle after the go bit clears
			mem_we_q <= prog_end;
		end
	end

	// done request; a new end beats a clear
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nv_done_flag_o <= 1'b0;
		end else if (prog_end) begin
			nv_done_flag_o <= 1'b1;
		end else if (done_clr_i) begin
			nv_done_flag_o <= 1'b0;
		end
	end

	nvb_array u_array (
		.clk_sys_i (clk_sys_i),
		.we_i      (mem_we_q),
		.waddr_i   (cap_addr_q),
		.wdata_i   (cap_data_q),
		.raddr_i   (index_q),
		.rdata_o   (mem_rdata)
	);

	always_comb begin
		rd_mux = 8'h00;
		if (hit_index) begin
			rd_mux = {1'b0, index_q};
		end else if (hit_value) begin
			rd_mux = value_q;
		end else if (hit_ctrl) begin
			rd_mux = {4'h0, prog_permit_q, prog_go_q, fetch_permit_q, fetch_go_q};
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sfr_rdata_o <= 8'h00;
		end else if (sfr_req_i.rd) begin
			sfr_rdata_o <= rd_mux;
		end
	end

	assign busy_o = (state_q != NVB_IDLE);

endmodule : nvb_ctrl
`default_nettype wire

//--- tb/nvb_ctrl_checker.sv
// nvb_ctrl_checker: port assertions for nvb_ctrl.
// assumes one clock domain; bound to every nvb_ctrl.
`timescale 1ns/100ps
`default_nettype none
module nvb_ctrl_checker
	import nvb_pkg::*;
(
	// clock and reset
	input wire logic         clk_sys_i,
	input wire logic         rst_n_i,
	// cpu register port
	input wire nvb_sfr_req_t sfr_req_i,
	input wire logic [7:0]   sfr_rdata_o,
	// done request and status
	input wire logic         done_clr_i,
	input wire logic         nv_done_flag_o,
	input wire logic         busy_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	wire ctl = sfr_req_i.indirect && sfr_req_i.bank == NVB_CTRL_BANK
		&& sfr_req_i.addr == NVB_CTRL_ADDR;
	wire idx = !sfr_req_i.indirect && sfr_req_i.addr == NVB_INDEX_ADDR;

	a_rdata_hold: assert property (!sfr_req_i.rd |=> $stable(sfr_rdata_o))
		else $error("read data moved without a read");
	a_index_msb: assert property (sfr_req_i.rd && idx |=> !sfr_rdata_o[7])
		else $error("index bit 7 not zero");
	a_ctrl_upper: assert property (sfr_req_i.rd && ctl |=> sfr_rdata_o[7:4] == 4'h0)
		else $error("control upper bits not zero");
	a_busy_cause: assert property ($rose(busy_o) |-> $past(ctl && sfr_req_i.wr))
		else $error("cycle started without control write");
	a_go_bit: assert property ($rose(busy_o) |-> $past(sfr_req_i.wdata[2] || sfr_req_i.wdata[0]))
		else $error("cycle started without a go bit");
	a_read_len: assert property ($rose(busy_o) && !$past(sfr_req_i.wdata[2]) |->
		##1 busy_o ##1 !busy_o)
		else $error("read cycle length wrong");
	a_write_len: assert property ($rose(busy_o) && $past(sfr_req_i.wdata[2]) |-> busy_o[*8])
		else $error("write cycle too short");
	a_done_cause: assert property ($rose(nv_done_flag_o) |-> $past(busy_o) && !busy_o)
		else $error("done flag without cycle end");
	a_done_sticky: assert property (nv_done_flag_o && !done_clr_i |=> nv_done_flag_o)
		else $error("done flag dropped by itself");
endmodule : nvb_ctrl_checker
bind nvb_ctrl nvb_ctrl_checker i_nvb_ctrl_checker (.clk_sys_i, .rst_n_i, .sfr_req_i,
	.sfr_rdata_o, .done_clr_i, .nv_done_flag_o, .busy_o);
`default_nettype wire

//--- tb/nvb_ctrl_tb.sv
// nvb_ctrl_tb: register-level scenarios for nvb_ctrl.
// assumes the checker is bound; slow clock runs free here.
`timescale 1ns/100ps
`default_nettype none
module nvb_ctrl_tb
	import nvb_pkg::*;
();
	localparam logic [7:0] IX = NVB_INDEX_ADDR;
	localparam logic [7:0] VL = NVB_VALUE_ADDR;
	logic         clk_sys_i  = 1'b0;
	logic         rst_n_i    = 1'b0;
	logic         fsub_i     = 1'b0;
	logic         done_clr_i = 1'b0;
	nvb_sfr_req_t req        = '0;
	logic [7:0]   rdata;
	logic [7:0]   v;
	logic         done;
	logic         busy;
	int           n_errors   = 0;
	int           n_compared = 0;

	always #20 clk_sys_i = ~clk_sys_i;
	// slow clock stable from the start
	// nba on the clock edge avoids a race with the first sync flop
	always begin
		repeat (4) @(posedge clk_sys_i);
		fsub_i <= ~fsub_i;
	end

	nvb_ctrl i_nvb_ctrl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sfr_req_i(req),
		.sfr_rdata_o(rdata), .fsub_i(fsub_i), .done_clr_i(done_clr_i),
		.nv_done_flag_o(done), .busy_o(busy));

	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic acc(input logic [7:0] a, input logic i, input logic [2:0] b,
		input logic w, input logic [7:0] d);
		@(posedge clk_sys_i);
		req <= '{a, b, i, w, !w, d};
		@(posedge clk_sys_i);
		req <= '0;
		@(posedge clk_sys_i);
		#1 v = rdata;
	endtask : acc
	task automatic rdx(input logic [7:0] a, input logic i, input logic [2:0] b,
		input logic [7:0] e);
		acc(a, i, b, 1'b0, 8'h00);
		chk(e, v);
	endtask : rdx
	task automatic wd(input logic [7:0] a, input logic [7:0] d);
		acc(a, 1'b0, 3'h0, 1'b1, d);
	endtask : wd
	task automatic wc(input logic [7:0] d);
		acc(NVB_CTRL_ADDR, 1'b1, NVB_CTRL_BANK, 1'b1, d);
	endtask : wc
	task automatic rc(input logic [7:0] e);
		rdx(NVB_CTRL_ADDR, 1'b1, NVB_CTRL_BANK, e);
	endtask : rc
	// a stuck go bit shows as a nonzero last read
	task automatic poll(input int b);
		for (int k = 0; k < 400; k++) begin
			acc(NVB_CTRL_ADDR, 1'b1, NVB_CTRL_BANK, 1'b0, 8'h00);
			if (v[b] === 1'b0) return;
		end
		chk(8'h00, v);
	endtask : poll

	task automatic t_regs;
		rdx(IX, 1'b0, 3'h0, 8'h00);
		rdx(VL, 1'b0, 3'h0, 8'h00);
		rc(8'h00);
		rdx(8'h2e, 1'b0, 3'h0, 8'h00);
		wd(IX, 8'hff);
		rdx(IX, 1'b0, 3'h0, 8'h7f);
		acc(VL, 1'b1, 3'h0, 1'b1, 8'ha5);
		acc(VL, 1'b1, 3'h2, 1'b1, 8'h11);
		rdx(VL, 1'b0, 3'h0, 8'ha5);
		acc(NVB_CTRL_ADDR, 1'b0, 3'h1, 1'b1, 8'h02);
		rc(8'h00);
		wc(8'hf2);
		rc(8'h02);
		wc(8'h00);
	endtask : t_regs
	task automatic t_refuse;
		wc(8'h04);
		chk(8'h00, {7'h0, busy});
		wc(8'h0c);
		rc(8'h08);
		wc(8'h01);
		rc(8'h00);
		chk(8'h00, {7'h0, busy});
	endtask : t_refuse
	task automatic t_write(input logic [7:0] i, input logic [7:0] d);
		wd(IX, i);
		wd(VL, d);
		wc(8'h08);
		wc(8'h0c);
		chk(8'h01, {7'h0, busy});
		rc(8'h0c);
		poll(2);
		chk(8'h01, {7'h0, done});
		rdx(VL, 1'b0, 3'h0, d);
		@(posedge clk_sys_i);
		done_clr_i <= 1'b1;
		@(posedge clk_sys_i);
		done_clr_i <= 1'b0;
		@(posedge clk_sys_i);
		#1 chk(8'h00, {7'h0, done});
		wc(8'h00);
	endtask : t_write
	task automatic t_read(input logic [7:0] i, input logic [7:0] d);
		wd(VL, 8'h00);
		wd(IX, i);
		wc(8'h02);
		wc(8'h03);
		poll(0);
		rdx(VL, 1'b0, 3'h0, d);
		wd(IX, 8'h00);
		rdx(VL, 1'b0, 3'h0, d);
		wc(8'h00);
	endtask : t_read

	task automatic end_sim;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_refuse();
		t_write(8'h05, 8'h3c);
		t_write(8'h7f, 8'hc3);
		t_read(8'h05, 8'h3c);
		t_read(8'h7f, 8'hc3);
		end_sim();
	end
	initial begin
		#400000;
		n_errors++;
		end_sim();
	end
endmodule : nvb_ctrl_tb
`default_nettype wire
